/* inc/tfoc_cfg.svh */
/*
 * Named constants of the temperature format and offset correction block:
 * register indices, field positions, codes and saturation limits.
 * Assumes it is included by its bare name wherever a constant is needed.
 */
`ifndef TFOC_CFG_SVH
`define TFOC_CFG_SVH

// ============================================================
// Register indices (byte address is four times the index)
// ============================================================
`define TFOC_IDX_TEMP_R1 8'h25
`define TFOC_IDX_TEMP_LOC 8'h26
`define TFOC_IDX_TEMP_R2 8'h27
`define TFOC_IDX_OFF_R1 8'h70
`define TFOC_IDX_OFF_LOC 8'h71
`define TFOC_IDX_OFF_R2 8'h72
`define TFOC_IDX_EXT_RES 8'h77
`define TFOC_IDX_CFG5 8'h7c

// ============================================================
// Channels
// ============================================================
`define TFOC_CH_R1 2'h0
`define TFOC_CH_LOC 2'h1
`define TFOC_CH_R2 2'h2
`define TFOC_CH_NONE 2'h3
`define TFOC_ALL_UNREAD 3'h7
`define TFOC_NONE_UNREAD 3'h0

// ============================================================
// Configuration fields
// ============================================================
`define TFOC_CFG_TWOS_BIT 0
`define TFOC_CFG_HALF_BIT 1

// ============================================================
// Fault byte codes and zero fraction; limits and bias in quarter degrees at 13 bits signed
// ============================================================
`define TFOC_FAULT_TWOS 8'h80
`define TFOC_FAULT_EXT 8'h00
`define TFOC_FRAC_ZERO 2'h0
`define TFOC_TW_MIN 13'h1e00
`define TFOC_TW_MAX 13'h01ff
`define TFOC_EX_MIN 13'h1f00
`define TFOC_EX_MAX 13'h02ff
`define TFOC_EX_BIAS 13'h0100

`endif

/* inc/tfoc_pkg.sv */
/*
 * Types of the temperature format and offset correction block.
 * Assumes nothing beyond the tools' SystemVerilog support.
 */
package tfoc_pkg;

    // One formatted result: integer-degree byte and quarter-degree bits.
    typedef struct packed {
        logic [7:0] int_byte;
        logic [1:0] frac;
    } tfoc_res_s;

    typedef struct packed {
        logic [2:0][7:0] offset;
        logic [2:0][7:0] live_int;
        logic [2:0][1:0] live_frac;
        logic [2:0][7:0] vis_int;
        logic [2:0][1:0] vis_frac;
        logic cfg_twos;
        logic cfg_half;
        logic freeze;
        logic [2:0] unread;
        logic ack;
        logic [31:0] dat;
    } tfoc_state_s;

endpackage : tfoc_pkg

/* hdl/tfoc_fmt.sv */
/*
 * Combinational formatter: adds the channel offset to one conversion,
 * saturates, and codes it as twos complement or offset-64 with a fault code.
 * Assumes a signed 11-bit quarter-degree input and a stable mode selection.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tfoc_cfg.svh"

module tfoc_fmt import tfoc_pkg::*; (
    // Conversion
    input wire logic [10:0] temp_i,
    input wire logic fault_i,
    // Correction and mode
    input wire logic [7:0] offset_i,
    input wire logic half_step_i,
    input wire logic twos_i,
    // Result
    output tfoc_res_s res_o
);

    logic [12:0] off_q;
    logic [12:0] sum;
    logic [12:0] lo;
    logic [12:0] hi;
    logic [12:0] clamped;
    logic [12:0] coded;

    always_comb begin
        // Clear is one degree, set is half.
        if (half_step_i) begin
            off_q = {{4{offset_i[7]}}, offset_i, 1'b0};
        end else begin
            off_q = {{3{offset_i[7]}}, offset_i, 2'b00};
        end
        sum = {{2{temp_i[10]}}, temp_i} + off_q;
        lo = twos_i ? `TFOC_TW_MIN : `TFOC_EX_MIN;
        hi = twos_i ? `TFOC_TW_MAX : `TFOC_EX_MAX;
        if ($signed(sum) < $signed(lo)) begin
            clamped = lo;
        end else if ($signed(sum) > $signed(hi)) begin
            clamped = hi;
        end else begin
            clamped = sum;
        end
        coded = twos_i ? clamped : clamped + `TFOC_EX_BIAS;
        res_o.int_byte = coded[9:2];
        res_o.frac = coded[1:0];
        if (fault_i) begin
            res_o.int_byte = twos_i ? `TFOC_FAULT_TWOS : `TFOC_FAULT_EXT;
            res_o.frac = `TFOC_FRAC_ZERO;
        end
    end

endmodule : tfoc_fmt
`default_nettype wire

/* hdl/tfoc_top.sv */
/*
 * Temperature format and offset correction with a classic Wishbone slave.
 * Holds per-channel offsets, the coding configuration, the formatted
 * results and the extended resolution register with its read freeze.
 * Assumes conversions come from logic on clk_i, one per valid pulse.
 */
// Implementation choice: register access over Wishbone.
// Notes on behaviour
// - Twos complement: signed degree byte; fault reads 0x80, fraction zero.
// - Extended range: byte is temperature plus 64; fault reads all zeros.
// - Two quarter-degree bits per channel sit in extended resolution.
// - Each channel's signed offset is added to every measurement.
// - Three offset registers, remote 1, local, remote 2, all reset to zero.
// - A configuration bit picks offset steps of one or half a degree.
// - A configuration bit set selects twos complement, clear offset-64.
// - Reading extended resolution freezes results until each byte is read.
`timescale 1ns/1ps
`default_nettype none
`include "tfoc_cfg.svh"

module tfoc_top import tfoc_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Conversion results
    input wire logic conv_valid_i,
    input wire logic [1:0] conv_chan_i,
    input wire logic [10:0] conv_temp_i,
    input wire logic conv_fault_i,
    // Status
    output logic frozen_o
);

    // ============================================================
    // Decode helpers
    // ============================================================
    function automatic logic [1:0] off_chan(input logic [7:0] idx);
        case (idx)
            `TFOC_IDX_OFF_R1: off_chan = `TFOC_CH_R1;
            `TFOC_IDX_OFF_LOC: off_chan = `TFOC_CH_LOC;
            `TFOC_IDX_OFF_R2: off_chan = `TFOC_CH_R2;
            default: off_chan = `TFOC_CH_NONE;
        endcase
    endfunction : off_chan

    function automatic logic [1:0] temp_chan(input logic [7:0] idx);
        case (idx)
            `TFOC_IDX_TEMP_R1: temp_chan = `TFOC_CH_R1;
            `TFOC_IDX_TEMP_LOC: temp_chan = `TFOC_CH_LOC;
            `TFOC_IDX_TEMP_R2: temp_chan = `TFOC_CH_R2;
            default: temp_chan = `TFOC_CH_NONE;
        endcase
    endfunction : temp_chan

    tfoc_state_s s;
    tfoc_state_s next_s;
    tfoc_res_s fmt;
    logic [7:0] conv_off;
    logic [7:0] idx;
    logic [1:0] oc;
    logic [1:0] tc;
    logic req;

    // ============================================================
    // Formatter
    // ============================================================
    // A channel code of three carries no offset, and its result is dropped.
    assign conv_off = (conv_chan_i == `TFOC_CH_NONE) ? 8'h00 :
                      s.offset[conv_chan_i];

    tfoc_fmt u_fmt (
        .temp_i(conv_temp_i),
        .fault_i(conv_fault_i),
        .offset_i(conv_off),
        .half_step_i(s.cfg_half),
        .twos_i(s.cfg_twos),
        .res_o(fmt)
    );

    // ============================================================
    // Next state
    // ============================================================
    always_comb begin
        next_s = s;
        idx = wb_adr_i[9:2];
        oc = off_chan(idx);
        tc = temp_chan(idx);
        req = wb_cyc_i & wb_stb_i & ~s.ack;
        next_s.ack = req;
        next_s.dat = 32'h0000_0000;

        // Results are coded at arrival; a later mode change does not
        // recode what is already stored, software must wait one conversion.
        if (conv_valid_i && conv_chan_i != `TFOC_CH_NONE) begin
            next_s.live_int[conv_chan_i] = fmt.int_byte;
            next_s.live_frac[conv_chan_i] = fmt.frac;
        end

        if (req) begin
            if (oc != `TFOC_CH_NONE) begin
                next_s.dat = {24'h00_0000, s.offset[oc]};
                if (wb_we_i && wb_sel_i[0]) begin
                    next_s.offset[oc] = wb_dat_i[7:0];
                end
            end else if (tc != `TFOC_CH_NONE) begin
                next_s.dat = {24'h00_0000, s.vis_int[tc]};
                if (!wb_we_i) begin
                    next_s.unread[tc] = 1'b0;
                end
            end else if (idx == `TFOC_IDX_EXT_RES) begin
                next_s.dat = {24'h00_0000, s.vis_frac[`TFOC_CH_R2],
                              s.vis_frac[`TFOC_CH_LOC],
                              s.vis_frac[`TFOC_CH_R1], 2'b00};
                if (!wb_we_i) begin
                    next_s.freeze = 1'b1;
                    next_s.unread = `TFOC_ALL_UNREAD;
                end
            end else if (idx == `TFOC_IDX_CFG5) begin
                next_s.dat = {30'h0000_0000, s.cfg_half, s.cfg_twos};
                if (wb_we_i && wb_sel_i[0]) begin
                    next_s.cfg_twos = wb_dat_i[`TFOC_CFG_TWOS_BIT];
                    next_s.cfg_half = wb_dat_i[`TFOC_CFG_HALF_BIT];
                end
            end
        end

        if (next_s.freeze && next_s.unread == `TFOC_NONE_UNREAD) begin
            next_s.freeze = 1'b0;
        end
        if (!next_s.freeze) begin
            next_s.vis_int = next_s.live_int;
            next_s.vis_frac = next_s.live_frac;
        end
    end

    // ============================================================
    // State register
    // ============================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Every field resets to zero, offsets included.
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign frozen_o = s.freeze;

endmodule : tfoc_top
`default_nettype wire

/* verification/tfoc_top_assertions.sv */
/* Port checker for tfoc_top: bus answer timing and the read freeze.
   Bound into every tfoc_top instance; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "tfoc_cfg.svh"
module tfoc_top_assertions (
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic frozen_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic rd_ext;
    logic rd_tmp;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_ext = take && !wb_we_i && wb_adr_i[9:2] == `TFOC_IDX_EXT_RES;
    assign rd_tmp = take && !wb_we_i
        && (wb_adr_i[9:2] == `TFOC_IDX_TEMP_R1
        || wb_adr_i[9:2] == `TFOC_IDX_TEMP_LOC
        || wb_adr_i[9:2] == `TFOC_IDX_TEMP_R2);
    a_ack_one: assert property (take |=> wb_ack_o)
        else $error("request not answered");
    a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_rst_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !frozen_o) else $error("busy in reset");
    a_freeze_set: assert property (rd_ext |=> frozen_o)
        else $error("fraction read did not freeze");
    a_freeze_hold: assert property (frozen_o && !rd_tmp |=> frozen_o)
        else $error("freeze ended without byte read");
    a_no_freeze: assert property (!frozen_o && !rd_ext |=> !frozen_o)
        else $error("freeze without fraction read");
    a_ext_low: assert property ($past(rd_ext) |-> wb_dat_o[1:0] == 2'h0)
        else $error("unused fraction bits set");
    c_ext_read: cover property (rd_ext);
    c_release: cover property (frozen_o ##1 !frozen_o);
    c_write: cover property (take && wb_we_i);
endmodule : tfoc_top_assertions
bind tfoc_top tfoc_top_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .frozen_o);
`default_nettype wire

/* verification/tfoc_host.sv */
/* Host model: a classic Wishbone master doing single register cycles.
   Assumes a slave that acks each request once. */
`timescale 1ns/1ps
`default_nettype none
module tfoc_host (
    // Clock
    input wire logic clk_i,
    // Wishbone master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [9:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 10'h0;
        wb_sel_o = 4'h1;
        wb_dat_o = 32'h0;
    end
    // Ack is read before this edge's updates land, i.e. as sampled.
    task automatic xfer(input logic we, input logic [7:0] idx,
        input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        int n;
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= {idx, 2'h0};
        wb_dat_o <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 40);
        ok = (wb_ack_i === 1'b1);
        rd = wb_dat_i[7:0];
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_dat_o <= ~wb_dat_o;
    endtask : xfer
endmodule : tfoc_host
`default_nettype wire

/* verification/temp_format_offset_correction_tb.sv */
/* Self-checking bench for tfoc_top with the host model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
module temp_format_offset_correction_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, cv = 1'b0, cf = 1'b0, frz;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr;
    logic [1:0] cc = 2'h0;
    logic [10:0] ct = 11'h0;
    int miscompares = 0;
    int checks = 0;
    initial forever #10 clk_i = ~clk_i;
    tfoc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .conv_valid_i(cv),
        .conv_chan_i(cc), .conv_temp_i(ct), .conv_fault_i(cf),
        .frozen_o(frz));
    tfoc_host u_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb),
        .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw),
        .wb_ack_i(ack), .wb_dat_i(dr));
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] i,
        input logic [7:0] d);
        logic [7:0] r;
        logic ok;
        u_host.xfer(w, i, d, r, ok);
        if (!ok) begin
            miscompares++;
            stop_test();
        end
        if (!w) chk(r, d);
    endtask : acc
    task automatic conv(input logic [1:0] c, input logic [10:0] t,
        input logic f);
        @(posedge clk_i);
        cv <= 1'b1;
        cc <= c;
        ct <= t;
        cf <= f;
        @(posedge clk_i);
        cv <= 1'b0;
    endtask : conv
    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_regs;
        acc(0, 8'h70, 8'h00);
        acc(0, 8'h71, 8'h00);
        acc(0, 8'h72, 8'h00);
        acc(0, 8'h7c, 8'h00);
        acc(1, 8'h72, 8'ha5);
        acc(0, 8'h72, 8'ha5);
        acc(1, 8'h7c, 8'hff);
        acc(0, 8'h7c, 8'h03);
        acc(1, 8'h25, 8'h77);
        acc(0, 8'h25, 8'h00);
        acc(0, 8'h10, 8'h00);
    endtask : t_regs
    task automatic t_twos;
        acc(1, 8'h7c, 8'h01);
        acc(1, 8'h71, 8'h05);
        conv(2'h0, 11'h7d8, 1'b0);
        conv(2'h1, 11'h1ff, 1'b0);
        conv(2'h2, 11'h000, 1'b1);
        acc(0, 8'h77, 8'h30);
        acc(0, 8'h25, 8'hf6);
        acc(0, 8'h26, 8'h7f);
        acc(0, 8'h27, 8'h80);
    endtask : t_twos
    task automatic t_ext;
        acc(1, 8'h7c, 8'h00);
        acc(1, 8'h71, 8'hfc);
        conv(2'h0, 11'h029, 1'b0);
        conv(2'h2, 11'h000, 1'b1);
        conv(2'h1, 11'h064, 1'b0);
        acc(0, 8'h26, 8'h55);
        acc(1, 8'h7c, 8'h02);
        conv(2'h1, 11'h064, 1'b0);
        acc(0, 8'h77, 8'h04);
        acc(0, 8'h25, 8'h4a);
        acc(0, 8'h26, 8'h57);
        acc(0, 8'h27, 8'h00);
    endtask : t_ext
    task automatic t_freeze;
        acc(0, 8'h77, 8'h04);
        conv(2'h0, 11'h000, 1'b0);
        acc(0, 8'h25, 8'h4a);
        acc(0, 8'h26, 8'h57);
        chk({7'h0, frz}, 8'h01);
        acc(0, 8'h27, 8'h00);
        chk({7'h0, frz}, 8'h00);
        acc(0, 8'h25, 8'h40);
    endtask : t_freeze
    // Saturation in both codings, and a channel code of three is dropped.
    task automatic t_sat;
        acc(1, 8'h7c, 8'h00);
        acc(1, 8'h71, 8'h7f);
        conv(2'h1, 11'h3ff, 1'b0);
        conv(2'h3, 11'h000, 1'b0);
        acc(0, 8'h26, 8'hff);
        acc(1, 8'h7c, 8'h01);
        acc(1, 8'h70, 8'h81);
        conv(2'h0, 11'h600, 1'b0);
        conv(2'h1, 11'h3ff, 1'b0);
        acc(0, 8'h77, 8'h30);
        acc(0, 8'h25, 8'h80);
        acc(0, 8'h26, 8'h7f);
        acc(0, 8'h27, 8'h00);
    endtask : t_sat
    // A reset in mid-run must bring offsets, coding and results back to zero.
    task automatic t_reset;
        acc(1, 8'h70, 8'h3c);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        acc(0, 8'h70, 8'h00);
        acc(0, 8'h72, 8'h00);
        acc(0, 8'h7c, 8'h00);
        acc(0, 8'h26, 8'h00);
    endtask : t_reset
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_twos();
        t_ext();
        t_freeze();
        t_sat();
        t_reset();
        stop_test();
    end
endmodule : temp_format_offset_correction_tb
`default_nettype wire
